//--- src/sfc_pkg.sv
package sfc_pkg;
	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_RDSR      = 8'h05;
	localparam logic [7:0] OP_WRSR      = 8'h01;
	localparam logic [7:0] OP_RST_EN    = 8'h66;
	localparam logic [7:0] OP_RST       = 8'h99;
	localparam logic [7:0] OP_ADDR4_IN  = 8'hb7;
	localparam logic [7:0] OP_ADDR4_OUT = 8'he9;
	localparam logic [7:0] OP_QUAD_IN   = 8'h35;
	localparam logic [7:0] OP_QUAD_OUT  = 8'hf5;
	localparam logic [7:0] OP_CONT_EXIT = 8'hff;
	localparam logic [7:0] OP_NVLK_WR   = 8'he3;
	localparam logic [7:0] OP_NVLK_RD   = 8'he2;
	localparam logic [7:0] OP_VLK_WR    = 8'he1;
	localparam logic [7:0] OP_VLK_RD    = 8'he0;
	localparam logic [7:0] OP_DTR_Q4    = 8'hbe;
	localparam logic [7:0] OP_FRD_Q4    = 8'hec;
	localparam logic [7:0] OP_FRD4      = 8'h0c;
	localparam logic [7:0] OP_RD4       = 8'h13;
	localparam logic [7:0] OP_ERASE1_4  = 8'h21;
	localparam logic [7:0] OP_ERASE3_4  = 8'hdc;
	localparam logic [7:0] OP_DTR_S1    = 8'h0e;
	localparam logic [7:0] OP_PP_Q4     = 8'h3e;

	// ------------------------------------------------------------
	// Status register layout and reset values, frame byte indices and continuous-mode key
	// ------------------------------------------------------------
	localparam logic [7:0] SR_NV_MASK   = 8'h9c;
	localparam logic [7:0] SR_VOL_MASK  = 8'h60;
	localparam int         SR_WEL_BIT   = 1;
	localparam logic [7:0] SR_NV_RST    = 8'h00;
	localparam logic [3:0] CONT_KEY     = 4'ha;
	localparam logic [2:0] ADDR4_LAST   = 3'h4;
	localparam logic [2:0] CONT_MODE_IX = 3'h5;

	// ------------------------------------------------------------
	// Line widths
	// ------------------------------------------------------------
	localparam logic [1:0] W1 = 2'h0;
	localparam logic [1:0] W2 = 2'h1;
	localparam logic [1:0] W4 = 2'h2;

	typedef enum logic [1:0] {
		SFC_IDLE,
		SFC_BODY,
		SFC_SKIP
	} sfc_state_t;
endpackage

//--- src/sfc_cmd_top.sv
`timescale 1ns/1ps
// How it works
// [R1] Hardware reset, software reset or power cycle return addressing to 24 bits.
// [R2] Software reset needs reset-enable 66h followed by reset 99h.
// [R3] Reset-enable and reset travel on 1, 2 or 4 lines per mode; no command here enters the 2-line mode, only 1 and 4 lines are used.
// [R4] Host leaves continuous 0-4-4 read mode before issuing reset.
// [R5] Status register one mixes volatile and non-volatile bits.
// [R6] Status write is rejected unless write-enable 06h came first.
// [R7] Non-volatile sector lock: E3h writes, E2h reads.
// [R8] Volatile sector lock: E1h writes, E0h reads.
// [R9] Double-rate 1-4-4 read BEh is accepted.
// [R10] No double-rate 1-2-2 read is offered.
// [R11] No double-rate 1-1-1 read 0Eh is offered.
// [R12] Erase types one to three with 32-bit address; no type four. Only types one (21h) and three (DCh) are decoded.
// [R13] Quad page program 3Eh is not accepted.
// [R14] Fast read 1-4-4 ECh with 32-bit address is accepted.
// [R15] Normal read 13h with 32-bit address is accepted.
// [R16] B7h enters 32-bit addressing without write-enable.
// [R17] Dedicated opcodes always carry a 32-bit address.
// [R18] Reset without directly preceding reset-enable is ignored; other supported opcodes clear it, unsupported ones leave it set.
// [R19] Unsupported opcodes are ignored until chip select rises.
module sfc_cmd_top #(
	parameter int NSEC = 16
) (
	input  wire logic       SYS_CLK,
	input  wire logic       RESET,
	input  wire logic       SPI_CLK,
	input  wire logic       SPI_CS_N,
	input  wire logic [3:0] SPI_IO_I,
	output logic      [3:0] SPI_IO_O,
	output logic      [3:0] SPI_IO_OE,
	output logic            ADDR_4BYTE,
	output logic            WRITE_EN,
	output logic      [1:0] LINE_WIDTH,
	output logic            CONT_MODE,
	output logic      [7:0] STATUS1,
	output logic            SOFT_RESET,
	output logic            CMD_VALID,
	output logic      [7:0] CMD_OPCODE,
	output logic            CMD_REJECT
);
	localparam int SW = $clog2(NSEC);

	// ------------------------------------------------------------
	// Link side, clocked by the host's serial clock
	// ------------------------------------------------------------
	// The width and read byte come from the system side. The width only changes
	// while chip select is high; the read byte settles once the second byte of the frame arrives.
	logic [1:0] width_q;
	logic [7:0] rd_byte_q;
	logic       cont_q;
	logic [7:0] l_sh_q;
	logic [2:0] l_cnt_q;
	logic [2:0] l_idx_q;
	logic [7:0] l_op_q;
	logic [7:0] l_byte_q;
	logic [2:0] l_bidx_q;
	logic       l_tog_q;
	logic       l_rd_q;
	logic [2:0] l_ocnt_q;
	logic [7:0] l_nx;
	logic [2:0] l_step;
	logic       l_done;

	always_comb begin
		case (width_q)
			sfc_pkg::W4: begin
				l_nx   = {l_sh_q[3:0], SPI_IO_I};
				l_step = 3'h4;
			end
			sfc_pkg::W2: begin
				l_nx   = {l_sh_q[5:0], SPI_IO_I[1:0]};
				l_step = 3'h2;
			end
			default: begin
				l_nx   = {l_sh_q[6:0], SPI_IO_I[0]};
				l_step = 3'h1;
			end
		endcase
		l_done = (l_cnt_q + l_step == 3'h0);
	end

	// Frame counters are cleared by chip select itself, since the serial
	// clock stops between frames and gives no edge to clear them.
	always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
		if (SPI_CS_N) begin
			l_cnt_q <= 3'h0;
			l_idx_q <= 3'h0;
			l_op_q  <= 8'h00;
			l_rd_q  <= 1'b0;
		end else begin
			l_cnt_q <= 3'(l_cnt_q + l_step); // R3
			if (l_done) begin
				if (l_idx_q != 3'h7)
					l_idx_q <= 3'(l_idx_q + 3'h1);
				if (l_idx_q == 3'h0 && !cont_q)
					l_op_q <= l_nx;
				if (l_idx_q == 3'h0 && !cont_q && l_nx == sfc_pkg::OP_RDSR)
					l_rd_q <= 1'b1;
				if (l_idx_q == sfc_pkg::ADDR4_LAST &&
				    (l_op_q == sfc_pkg::OP_NVLK_RD || l_op_q == sfc_pkg::OP_VLK_RD))
					l_rd_q <= 1'b1; // R17
			end
		end
	end

	always_ff @(posedge SPI_CLK) begin
		l_sh_q <= l_nx;
		if (l_done && !SPI_CS_N) begin
			l_byte_q <= l_nx;
			l_bidx_q <= l_idx_q;
		end
	end

	// The toggle has no chip-select clear, so the system reset gives it a known
	// level; the serial clock is idle while that reset is held.
	always_ff @(posedge SPI_CLK or posedge RESET) begin
		if (RESET)
			l_tog_q <= 1'b0;
		else if (l_done && !SPI_CS_N)
			l_tog_q <= ~l_tog_q;
	end

	always_ff @(negedge SPI_CLK or posedge SPI_CS_N) begin
		if (SPI_CS_N) begin
			l_ocnt_q  <= 3'h0;
			SPI_IO_OE <= 4'h0;
			SPI_IO_O  <= 4'h0;
		end else if (l_rd_q) begin
			l_ocnt_q <= 3'(l_ocnt_q + l_step);
			case (width_q)
				sfc_pkg::W4: begin
					SPI_IO_OE <= 4'hf;
					SPI_IO_O  <= l_ocnt_q[2] ? rd_byte_q[3:0] : rd_byte_q[7:4];
				end
				sfc_pkg::W2: begin
					SPI_IO_OE <= 4'h3;
					SPI_IO_O  <= {2'h0, rd_byte_q[3'(3'h6 - l_ocnt_q) +: 2]};
				end
				default: begin
					SPI_IO_OE <= 4'h2;
					SPI_IO_O  <= {2'h0, rd_byte_q[3'h7 - l_ocnt_q], 1'b0};
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Crossing into the system clock
	// ------------------------------------------------------------
	logic [2:0] tog_s_q;
	logic [1:0] cs_s_q;
	logic       cs_prev_q;
	logic       byte_ev;
	logic       frame_end;

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			tog_s_q   <= 3'h0;
			cs_s_q    <= 2'h3;
			cs_prev_q <= 1'b1;
		end else begin
			tog_s_q   <= {tog_s_q[1:0], l_tog_q};
			cs_s_q    <= {cs_s_q[0], SPI_CS_N};
			cs_prev_q <= cs_s_q[1];
		end
	end

	// The byte and its index were written with the toggle and stay put for
	// at least two serial clocks, longer than the toggle takes to arrive.
	assign byte_ev   = tog_s_q[2] ^ tog_s_q[1];
	assign frame_end = cs_s_q[1] & ~cs_prev_q;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	sfc_pkg::sfc_state_t st_q;
	logic [7:0]    op_q;
	logic [7:0]    data_q;
	logic          data_ok_q;
	logic [SW-1:0] sec_q;
	logic          lock_rd_q;
	logic          addr4_q;
	logic          wel_q;
	logic          rst_en_q;
	logic [7:0]    sr_nv_q;
	logic [7:0]    sr_vol_q;
	logic [NSEC-1:0] nv_lock_q;
	logic [NSEC-1:0] v_lock_q;
	logic          known;
	logic [7:0]    sr_view;

	assign sr_view = sr_nv_q | sr_vol_q | (8'(wel_q) << sfc_pkg::SR_WEL_BIT); // R5

	always_comb begin
		case (l_byte_q)
			sfc_pkg::OP_WREN, sfc_pkg::OP_WRDI, sfc_pkg::OP_RDSR,
			sfc_pkg::OP_WRSR, sfc_pkg::OP_RST_EN, sfc_pkg::OP_RST,
			sfc_pkg::OP_ADDR4_IN, sfc_pkg::OP_ADDR4_OUT, sfc_pkg::OP_QUAD_IN,
			sfc_pkg::OP_QUAD_OUT, sfc_pkg::OP_CONT_EXIT,
			sfc_pkg::OP_NVLK_WR, sfc_pkg::OP_NVLK_RD, // R7
			sfc_pkg::OP_VLK_WR, sfc_pkg::OP_VLK_RD, // R8
			sfc_pkg::OP_DTR_Q4, // R9
			sfc_pkg::OP_FRD_Q4, // R14
			sfc_pkg::OP_FRD4,
			sfc_pkg::OP_RD4, // R15
			sfc_pkg::OP_ERASE1_4, sfc_pkg::OP_ERASE3_4: known = 1'b1; // R12
			default: known = 1'b0; // R10 R11 R13
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			st_q      <= sfc_pkg::SFC_IDLE;
			op_q      <= 8'h00;
			data_q    <= 8'h00;
			data_ok_q <= 1'b0;
			sec_q     <= '0;
			lock_rd_q <= 1'b0;
		end else if (frame_end) begin
			st_q      <= sfc_pkg::SFC_IDLE;
			data_ok_q <= 1'b0;
			lock_rd_q <= 1'b0;
		end else if (byte_ev) begin
			if (l_bidx_q == 3'h0 && !cont_q) begin
				op_q <= l_byte_q;
				st_q <= known ? sfc_pkg::SFC_BODY : sfc_pkg::SFC_SKIP; // R19
			end else if (l_bidx_q == 3'h0) begin
				op_q <= (l_byte_q == sfc_pkg::OP_CONT_EXIT) ? l_byte_q : sfc_pkg::OP_FRD_Q4; // R4
				st_q <= sfc_pkg::SFC_BODY;
			end else if (st_q == sfc_pkg::SFC_BODY) begin
				if (l_bidx_q == 3'h1) begin
					data_q    <= l_byte_q;
					data_ok_q <= 1'b1;
					sec_q     <= l_byte_q[SW-1:0]; // R17
					lock_rd_q <= (op_q == sfc_pkg::OP_NVLK_RD || op_q == sfc_pkg::OP_VLK_RD);
				end
				if (l_bidx_q == sfc_pkg::CONT_MODE_IX)
					data_q <= l_byte_q;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			rd_byte_q <= 8'h00;
		else if (lock_rd_q && op_q == sfc_pkg::OP_NVLK_RD)
			rd_byte_q <= {7'h00, nv_lock_q[sec_q]};
		else if (lock_rd_q)
			rd_byte_q <= {7'h00, v_lock_q[sec_q]};
		else
			rd_byte_q <= sr_view;
	end

	// ------------------------------------------------------------
	// Effects applied when chip select rises
	// ------------------------------------------------------------
	logic run;
	logic go_rst;

	assign run    = frame_end && st_q == sfc_pkg::SFC_BODY;
	assign go_rst = run && op_q == sfc_pkg::OP_RST && rst_en_q; // R2 R18

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			rst_en_q <= 1'b0;
		end else if (run) begin
			rst_en_q <= (op_q == sfc_pkg::OP_RST_EN); // R2 R18
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET || go_rst) begin
			addr4_q  <= 1'b0; // R1
			wel_q    <= 1'b0;
			width_q  <= sfc_pkg::W1;
			cont_q   <= 1'b0;
			sr_vol_q <= 8'h00;
			v_lock_q <= '0;
		end else if (run) begin
			case (op_q)
				sfc_pkg::OP_ADDR4_IN:  addr4_q <= 1'b1; // R16
				sfc_pkg::OP_ADDR4_OUT: addr4_q <= 1'b0;
				sfc_pkg::OP_WREN:      wel_q   <= 1'b1;
				sfc_pkg::OP_WRDI:      wel_q   <= 1'b0;
				sfc_pkg::OP_QUAD_IN:   width_q <= sfc_pkg::W4; // R3
				sfc_pkg::OP_QUAD_OUT:  width_q <= sfc_pkg::W1;
				sfc_pkg::OP_CONT_EXIT: cont_q  <= 1'b0; // R4
				sfc_pkg::OP_FRD_Q4:    cont_q  <= (data_q[7:4] == sfc_pkg::CONT_KEY);
				sfc_pkg::OP_WRSR: begin
					if (wel_q && data_ok_q) begin
						sr_vol_q <= data_q & sfc_pkg::SR_VOL_MASK; // R5 R6
						wel_q    <= 1'b0;
					end
				end
				sfc_pkg::OP_VLK_WR: begin
					if (data_ok_q)
						v_lock_q[sec_q] <= 1'b1; // R8
				end
				sfc_pkg::OP_NVLK_WR:   wel_q   <= 1'b0;
				default:               ;
			endcase
		end
	end

	// Non-volatile state survives a software reset, only a power cycle
	// (the system reset here) brings it back.
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			sr_nv_q   <= sfc_pkg::SR_NV_RST;
			nv_lock_q <= '0;
		end else if (run && wel_q && data_ok_q) begin
			if (op_q == sfc_pkg::OP_WRSR)
				sr_nv_q <= data_q & sfc_pkg::SR_NV_MASK; // R5 R6
			if (op_q == sfc_pkg::OP_NVLK_WR)
				nv_lock_q[sec_q] <= 1'b1; // R7
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			SOFT_RESET <= 1'b0;
			CMD_VALID  <= 1'b0;
			CMD_REJECT <= 1'b0;
			CMD_OPCODE <= 8'h00;
		end else begin
			SOFT_RESET <= go_rst;
			CMD_VALID  <= run && !(op_q == sfc_pkg::OP_RST && !rst_en_q);
			CMD_REJECT <= run && !wel_q &&
			              (op_q == sfc_pkg::OP_WRSR || op_q == sfc_pkg::OP_NVLK_WR); // R6
			if (run)
				CMD_OPCODE <= op_q;
		end
	end

	assign ADDR_4BYTE = addr4_q;
	assign WRITE_EN   = wel_q;
	assign LINE_WIDTH = width_q;
	assign CONT_MODE  = cont_q;
	assign STATUS1    = rd_byte_q;
endmodule

//--- sim/sfc_cmd_monitor.sv
`timescale 1ns/1ps
module sfc_cmd_monitor (
	input wire logic       SYS_CLK,
	input wire logic       RESET,
	input wire logic       SPI_CS_N,
	input wire logic       ADDR_4BYTE,
	input wire logic       WRITE_EN,
	input wire logic [1:0] LINE_WIDTH,
	input wire logic       CONT_MODE,
	input wire logic       SOFT_RESET,
	input wire logic       CMD_VALID,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic       CMD_REJECT
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	chk_hw_reset_clear: assert property ($fell(RESET) |-> !ADDR_4BYTE && !WRITE_EN)
		else $error("addressing not cleared by hardware reset");
	chk_soft_reset_addr: assert property (SOFT_RESET |-> !ADDR_4BYTE && !WRITE_EN)
		else $error("addressing not cleared by soft reset");
	chk_soft_reset_width: assert property (SOFT_RESET |-> LINE_WIDTH == sfc_pkg::W1 && !CONT_MODE)
		else $error("line width not cleared by soft reset");
	chk_soft_reset_pulse: assert property (SOFT_RESET |=> !SOFT_RESET ##1 !SOFT_RESET)
		else $error("soft reset pulse too long");
	chk_reject_no_wel: assert property (CMD_REJECT |-> !WRITE_EN && CMD_VALID &&
		(CMD_OPCODE == sfc_pkg::OP_WRSR || CMD_OPCODE == sfc_pkg::OP_NVLK_WR))
		else $error("write rejected while write enable set");
	chk_wrsr_clears_wel: assert property (CMD_VALID && CMD_OPCODE == sfc_pkg::OP_WRSR |-> !WRITE_EN)
		else $error("write enable kept after status write");
	chk_addr_after_cs: assert property ($rose(ADDR_4BYTE) |-> SPI_CS_N && $past(SPI_CS_N))
		else $error("addressing changed inside a frame");
	chk_no_bad_opcode: assert property (CMD_VALID |-> CMD_OPCODE != sfc_pkg::OP_DTR_S1 && CMD_OPCODE != sfc_pkg::OP_PP_Q4)
		else $error("unsupported opcode completed");
	chk_addr4_no_wel: assert property (CMD_VALID && CMD_OPCODE == sfc_pkg::OP_ADDR4_IN |-> ADDR_4BYTE)
		else $error("32-bit entry did not take effect");
endmodule

bind sfc_cmd_top sfc_cmd_monitor sfc_cmd_monitor_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
	.SPI_CS_N(SPI_CS_N), .ADDR_4BYTE(ADDR_4BYTE), .WRITE_EN(WRITE_EN), .LINE_WIDTH(LINE_WIDTH),
	.CONT_MODE(CONT_MODE), .SOFT_RESET(SOFT_RESET), .CMD_VALID(CMD_VALID),
	.CMD_OPCODE(CMD_OPCODE), .CMD_REJECT(CMD_REJECT));

//--- sim/sfc_host_model.sv
`timescale 1ns/1ps
module sfc_host_model (
	output logic       SPI_CLK,
	output logic       SPI_CS_N,
	output logic [3:0] SPI_IO_I,
	input  wire logic [3:0] SPI_IO_O
);
	logic [7:0] rd_q;
	initial begin
		SPI_CLK = 1'b0;
		SPI_CS_N = 1'b1;
		SPI_IO_I = 4'h5;
		rd_q = 8'h00;
	end
	// The clock stands still between frames; idle lines toggle so stale data is never read.
	task automatic frame(input logic [47:0] d, input int nb, input logic [1:0] w0, input logic [1:0] w1);
		logic [7:0] v;
		int k;
		SPI_CS_N = 1'b0;
		for (int b = 0; b < nb; b++) begin
			k = ((b == 0) ? w0 : w1) == 2'h2 ? 4 : (((b == 0) ? w0 : w1) == 2'h1 ? 2 : 1);
			for (int i = 8; i > 0; i -= k) begin
				v = d[47 - 8 * b -: 8] >> (i - k);
				SPI_IO_I = v[3:0] & 4'((1 << k) - 1);
				#32 SPI_CLK = 1'b1;
				rd_q = {rd_q[6:0], SPI_IO_O[1]};
				#32 SPI_CLK = 1'b0;
			end
		end
		#32 SPI_CS_N = 1'b1;
		SPI_IO_I = ~SPI_IO_I;
		#300;
	endtask
endmodule

//--- sim/tb_spi_flash_reset_and_cmd_set.sv
`timescale 1ns/1ps
module tb_spi_flash_reset_and_cmd_set;
	logic       sys_clk;
	logic       reset;
	logic       spi_clk;
	logic       spi_cs_n;
	logic [3:0] io_i;
	logic [3:0] io_o;
	logic [3:0] io_oe;
	logic       addr4;
	logic       wel;
	logic [1:0] width;
	logic       cont;
	logic [7:0] status;
	logic       srst;
	logic       valid;
	logic [7:0] opcode;
	logic       reject;
	int         n_errors;
	int         cmp_count;
	int         nv;
	int         nr;
	int         ns;
	logic [7:0] ok_ops [9] = '{8'he2, 8'he1, 8'he0, 8'hbe, 8'h21, 8'hdc, 8'hec, 8'h0c, 8'h13};

	sfc_cmd_top sfc_cmd_top_inst (.SYS_CLK(sys_clk), .RESET(reset), .SPI_CLK(spi_clk),
		.SPI_CS_N(spi_cs_n), .SPI_IO_I(io_i), .SPI_IO_O(io_o), .SPI_IO_OE(io_oe),
		.ADDR_4BYTE(addr4), .WRITE_EN(wel), .LINE_WIDTH(width), .CONT_MODE(cont),
		.STATUS1(status), .SOFT_RESET(srst), .CMD_VALID(valid), .CMD_OPCODE(opcode),
		.CMD_REJECT(reject));
	sfc_host_model sfc_host_model_inst (.SPI_CLK(spi_clk), .SPI_CS_N(spi_cs_n),
		.SPI_IO_I(io_i), .SPI_IO_O(io_o));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		nv += (valid === 1'b1);
		nr += (reject === 1'b1);
		ns += (srst === 1'b1);
	end

	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic run(input logic [47:0] d, input int nb, input logic [1:0] w0 = 2'h0,
		input logic [1:0] w1 = 2'h0);
		sfc_host_model_inst.frame(d, nb, w0, w1);
	endtask
	task automatic rdsr_check(input logic [7:0] exp);
		run({sfc_pkg::OP_RDSR, 40'h0}, 2);
		check("status read", sfc_host_model_inst.rd_q & 8'hfc, exp);
		check("status port", status & 8'hfc, exp);
		check("io released", {4'h0, io_oe}, 8'h00);
	endtask

	task automatic t_addr4;
		int v0 = nv;
		run({sfc_pkg::OP_ADDR4_IN, 40'h0}, 1);
		check("addr4 entry", {7'h0, addr4}, 8'h01);
		check("addr4 valid", 8'(nv - v0), 8'h01);
	endtask
	task automatic t_status;
		int r0 = nr;
		run({sfc_pkg::OP_WRSR, 8'hff, 32'h0}, 2);
		check("wrsr reject", 8'(nr - r0), 8'h01);
		run({sfc_pkg::OP_NVLK_WR, 40'h0}, 5);
		check("lock reject", 8'(nr - r0), 8'h02);
		run({sfc_pkg::OP_WREN, 40'h0}, 1);
		check("wel set", {7'h0, wel}, 8'h01);
		run({sfc_pkg::OP_WRSR, 8'hff, 32'h0}, 2);
		check("wel cleared", {7'h0, wel}, 8'h00);
		rdsr_check(8'hfc);
	endtask
	task automatic t_reset;
		int s0 = ns;
		run({sfc_pkg::OP_RST, 40'h0}, 1);
		check("lone reset", 8'(ns - s0), 8'h00);
		run({sfc_pkg::OP_RST_EN, 40'h0}, 1);
		run({sfc_pkg::OP_WREN, 40'h0}, 1);
		run({sfc_pkg::OP_RST, 40'h0}, 1);
		check("broken pair", 8'(ns - s0), 8'h00);
		check("addr4 kept", {7'h0, addr4}, 8'h01);
		run({sfc_pkg::OP_RST_EN, 40'h0}, 1);
		run({sfc_pkg::OP_DTR_S1, 40'h0}, 1);
		run({sfc_pkg::OP_RST, 40'h0}, 1);
		check("pair reset", 8'(ns - s0), 8'h01);
		check("addr4 left", {6'h0, addr4, wel}, 8'h00);
		rdsr_check(8'h9c);
	endtask
	task automatic t_quad;
		int s0 = ns;
		run({sfc_pkg::OP_QUAD_IN, 40'h0}, 1);
		check("quad width", {6'h0, width}, {6'h0, sfc_pkg::W4});
		run({sfc_pkg::OP_ADDR4_IN, 40'h0}, 1, 2'h2, 2'h2);
		run({sfc_pkg::OP_FRD_Q4, 32'h0, 8'ha0}, 6, 2'h2, 2'h2);
		check("cont entry", {7'h0, cont}, 8'h01);
		run({sfc_pkg::OP_CONT_EXIT, 40'h0}, 1, 2'h2, 2'h2);
		check("cont exit", {7'h0, cont}, 8'h00);
		run({sfc_pkg::OP_RST_EN, 40'h0}, 1, 2'h2, 2'h2);
		run({sfc_pkg::OP_RST, 40'h0}, 1, 2'h2, 2'h2);
		check("quad reset", 8'(ns - s0), 8'h01);
		check("width back", {5'h0, width, addr4}, 8'h00);
	endtask
	task automatic t_locks;
		run({sfc_pkg::OP_VLK_WR, 8'h03, 32'h0}, 5);
		run({sfc_pkg::OP_VLK_RD, 8'h03, 32'h0}, 6);
		check("vlock set", sfc_host_model_inst.rd_q, 8'h01);
		run({sfc_pkg::OP_VLK_RD, 8'h02, 32'h0}, 6);
		check("vlock other", sfc_host_model_inst.rd_q, 8'h00);
		run({sfc_pkg::OP_WREN, 40'h0}, 1);
		run({sfc_pkg::OP_NVLK_WR, 8'h05, 32'h0}, 5);
		run({sfc_pkg::OP_RST_EN, 40'h0}, 1);
		run({sfc_pkg::OP_RST, 40'h0}, 1);
		run({sfc_pkg::OP_VLK_RD, 8'h03, 32'h0}, 6);
		check("vlock cleared", sfc_host_model_inst.rd_q, 8'h00);
		run({sfc_pkg::OP_NVLK_RD, 8'h05, 32'h0}, 6);
		check("nvlock kept", sfc_host_model_inst.rd_q, 8'h01);
	endtask
	task automatic t_ops;
		int v0;
		foreach (ok_ops[i]) begin
			v0 = nv;
			run({ok_ops[i], 40'h0}, 6);
			check("op valid", 8'(nv - v0), 8'h01);
			check("op code", opcode, ok_ops[i]);
		end
		v0 = nv;
		run({sfc_pkg::OP_DTR_S1, 40'h0}, 6);
		run({sfc_pkg::OP_PP_Q4, 40'h0}, 6);
		check("bad ops", 8'(nv - v0), 8'h00);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#1ms;
		n_errors++;
		end_of_test();
	end
	initial begin
		reset = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		nv = 0;
		nr = 0;
		ns = 0;
		repeat (10) @(negedge sys_clk);
		reset = 1'b0;
		repeat (8) @(negedge sys_clk);
		check("reset addr4", {7'h0, addr4}, 8'h00);
		t_addr4();
		t_status();
		t_reset();
		t_quad();
		t_locks();
		t_ops();
		end_of_test();
	end
endmodule
